/* design/spx_pkg.sv */
package spx_pkg;

    // ----------------------------------------------------------------
    // Link widths
    // ----------------------------------------------------------------
    localparam int STATION_W = 8;
    localparam int REG_W     = 16;
    localparam int SPEED_W   = 3;
    localparam int ENTRY_W   = 4;

    // ----------------------------------------------------------------
    // Indexer values
    // ----------------------------------------------------------------
    localparam logic [3:0]         OPSEL_INDEXER   = 4'h1;
    localparam logic [ENTRY_W-1:0] ENTRY_FIRST     = 4'h1;
    localparam logic [ENTRY_W-1:0] ENTRY_TABLE_MAX = 4'h7;

    // ----------------------------------------------------------------
    // Host register offsets and fields
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_STATION   = 8'h04;
    localparam logic [7:0] OFS_SPEED     = 8'h08;
    localparam logic [7:0] OFS_NEXT_REG  = 8'h0C;
    localparam logic [7:0] OFS_TOS_REG   = 8'h10;
    localparam logic [7:0] OFS_CMD       = 8'h14;
    localparam logic [7:0] OFS_STATUS    = 8'h18;
    localparam int CTRL_MODE1_BIT = 0;
    localparam int CTRL_MODE2_BIT = 1;
    localparam int CTRL_RSEL_BIT  = 2;
    localparam int CMD_START_BIT  = 0;
    localparam logic [2:0] CTRL_RESET = 3'h0;

    // ----------------------------------------------------------------
    // Cycle counts
    // ----------------------------------------------------------------
    localparam int START_HOLD_CYCLES = 4;

    // ----------------------------------------------------------------
    // Device sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [0:0] {
        SPX_IDLE,
        SPX_MOVE
    } spx_state_type;

endpackage

/* design/spx_link_if.sv */
`timescale 1ns/100ps
interface spx_link_if;
    import spx_pkg::*;

    // Master to drive
    logic                 start_request_bit;
    logic                 op_mode_select_first;
    logic                 op_mode_select_second;
    logic                 register_select_system_bit;
    logic [4:0]           target_station_select_low_bits;
    logic [2:0]           target_station_select_high_bits;
    logic [SPEED_W-1:0]   speed_select_bits;
    logic [REG_W-1:0]     next_station_remote_register;
    logic [REG_W-1:0]     table_or_speed_remote_register;
    // Drive to master
    logic                 in_position_flag;
    logic                 movement_complete_flag;
    logic                 home_not_done_alarm;
    logic                 station_range_warning;

    modport drive (
        input  start_request_bit, op_mode_select_first,
               op_mode_select_second, register_select_system_bit,
               target_station_select_low_bits,
               target_station_select_high_bits, speed_select_bits,
               next_station_remote_register,
               table_or_speed_remote_register,
        output in_position_flag, movement_complete_flag,
               home_not_done_alarm, station_range_warning
    );

    modport master (
        output start_request_bit, op_mode_select_first,
               op_mode_select_second, register_select_system_bit,
               target_station_select_low_bits,
               target_station_select_high_bits, speed_select_bits,
               next_station_remote_register,
               table_or_speed_remote_register,
        input  in_position_flag, movement_complete_flag,
               home_not_done_alarm, station_range_warning
    );

endinterface

/* design/spx_drive.sv */
// Notes on behaviour
// (R1) Start without home return raises alarm
// (R2) Station above count minus one warns
// (R3) Start ignored during move; wait complete
// (R4) Speed selection sampled only at start
// (R5) Post-position torque after delay from in-position
// (R6) Power-on in-position if already at station
// (R7) Register mode takes station from register
// (R8) Method parameter: table number or direct speed
// (R9) Master sets both mode bits for mode
// (R10) Master sets register-select bit for registers
// (R11) Station numbering direction ignored here
// (R12) Register table mode accepts entries 1 to 7
// (R13) Table mode uses register-selected entry
// (R14) Direct speed only with two stations occupied
// (R15) Master updates selections before start
// (R16) Indexer active only when top digit one
// (R17) Shortest rotation direction chosen automatically
// (R18) Bit station value is eight-bit binary
// (R19) Speed bits plus one select entry
// (R20) Complete drops at start, rises at arrival
//
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
module spx_drive
    import spx_pkg::*;
#(
    parameter int DELAY_W = 16
) (
    input  wire logic                 clk_sys,
    input  wire logic                 nrst,
    spx_link_if.drive                 link,
    input  wire logic [3:0]           operation_select_param,
    input  wire logic [STATION_W:0]   station_count_param,
    input  wire logic                 speed_data_method_param,
    input  wire logic [DELAY_W-1:0]   torque_limit_delay_param,
    input  wire logic                 two_stations_occupied,
    input  wire logic                 home_return_done,
    input  wire logic                 alarm_clear,
    input  wire logic                 position_in_range,
    input  wire logic [STATION_W-1:0] current_station,
    input  wire logic                 move_arrived,
    output logic                      move_start,
    output logic [STATION_W-1:0]      move_target,
    output logic                      move_reverse,
    output logic [ENTRY_W-1:0]        move_entry,
    output logic                      move_direct,
    output logic [REG_W-1:0]          move_speed,
    output logic                      torque_post_select
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        spx_state_type        state;
        logic                 init_done;
        logic                 start_prev;
        logic                 in_pos;
        logic                 complete;
        logic                 alarm;
        logic                 warning;
        logic                 start_pulse;
        logic [STATION_W-1:0] target;
        logic                 reverse;
        logic [ENTRY_W-1:0]   entry;
        logic                 direct;
        logic [REG_W-1:0]     speed;
        logic                 delay_run;
        logic [DELAY_W-1:0]   delay_cnt;
        logic                 torque_post;
    } spx_drive_state_type;

    spx_drive_state_type st_reg;
    spx_drive_state_type st_next;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Forward distance modulo station count, compared to half a turn
    function automatic logic shortest_is_reverse(
        input logic [STATION_W-1:0] from_st,
        input logic [STATION_W-1:0] to_st,
        input logic [STATION_W:0]   count
    );
        logic [STATION_W:0] fwd;
        fwd = {1'b0, to_st} - {1'b0, from_st};
        if (to_st < from_st) begin
            fwd = fwd + count;
        end
        return ({fwd, 1'b0} > count);
    endfunction

    logic                 mode_active;
    logic                 start_rise;
    logic [STATION_W-1:0] sel_station;
    logic [ENTRY_W-1:0]   sel_entry;
    logic                 sel_direct;
    logic [REG_W-1:0]     tos_val;

    // Mode gating and start edge
    assign mode_active = (operation_select_param == OPSEL_INDEXER)   // R16
        && link.op_mode_select_first && link.op_mode_select_second;  // R9
    assign start_rise  = link.start_request_bit && !st_reg.start_prev;
    assign tos_val     = link.table_or_speed_remote_register;

    // Target and speed source selection
    always_comb begin
        sel_direct = 1'b0;
        if (link.register_select_system_bit) begin                   // R10
            sel_station = link.next_station_remote_register[STATION_W-1:0]; // R7
            if (speed_data_method_param && two_stations_occupied) begin  // R8
                sel_direct = 1'b1;                                   // R14
                sel_entry  = ENTRY_FIRST;                            // R14
            end else if (tos_val >= REG_W'(ENTRY_FIRST)
                         && tos_val <= REG_W'(ENTRY_TABLE_MAX)) begin
                sel_entry = tos_val[ENTRY_W-1:0];                    // R12 R13
            end else begin
                sel_entry = ENTRY_FIRST;
            end
        end else begin
            sel_station = {link.target_station_select_high_bits,     // R18
                           link.target_station_select_low_bits};
            if (two_stations_occupied) begin
                sel_entry = ENTRY_W'({1'b0, link.speed_select_bits})
                            + ENTRY_FIRST;                           // R19
            end else begin
                sel_entry = ENTRY_FIRST;
            end
        end
    end

    // Sequencer next state
    always_comb begin
        st_next             = st_reg;
        st_next.start_pulse = 1'b0;
        st_next.start_prev  = link.start_request_bit;
        if (!st_reg.init_done) begin
            st_next.init_done = 1'b1;
            st_next.in_pos    = position_in_range;                   // R6
        end
        if (alarm_clear) begin
            st_next.alarm   = 1'b0;
            st_next.warning = 1'b0;
        end
        unique case (st_reg.state)
            SPX_IDLE: begin
                if (start_rise && mode_active && st_reg.init_done) begin
                    if (!home_return_done) begin
                        st_next.alarm = 1'b1;                        // R1
                    end else if ({1'b0, sel_station}
                                 > station_count_param - 1'b1) begin
                        st_next.warning = 1'b1;                      // R2
                    end else begin
                        st_next.state       = SPX_MOVE;
                        st_next.start_pulse = 1'b1;
                        st_next.target      = sel_station;
                        st_next.entry       = sel_entry;             // R4
                        st_next.direct      = sel_direct;
                        st_next.speed       = sel_direct ? tos_val : '0;
                        st_next.reverse     = shortest_is_reverse(   // R17 R11
                            current_station, sel_station,
                            station_count_param);
                        st_next.complete    = 1'b0;                  // R20
                        st_next.in_pos      = 1'b0;
                        st_next.torque_post = 1'b0;
                        st_next.delay_run   = 1'b0;
                    end
                end
            end
            SPX_MOVE: begin
                // Further starts fall through unused here
                if (move_arrived) begin                              // R3
                    st_next.state     = SPX_IDLE;
                    st_next.complete  = 1'b1;                        // R20
                    st_next.in_pos    = 1'b1;
                    st_next.delay_run = 1'b1;                        // R5
                    st_next.delay_cnt = torque_limit_delay_param;
                end
            end
        endcase
        // Torque limit switch delay
        if (st_reg.delay_run) begin
            if (st_reg.delay_cnt == '0) begin
                st_next.delay_run   = 1'b0;
                st_next.torque_post = 1'b1;                          // R5
            end else begin
                st_next.delay_cnt = st_reg.delay_cnt - 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_reg          <= '0;
            st_reg.state    <= SPX_IDLE;
            st_reg.complete <= 1'b1;
            st_reg.entry    <= ENTRY_FIRST;
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign link.in_position_flag       = st_reg.in_pos;
    assign link.movement_complete_flag = st_reg.complete;
    assign link.home_not_done_alarm    = st_reg.alarm;
    assign link.station_range_warning  = st_reg.warning;
    assign move_start                  = st_reg.start_pulse;
    assign move_target                 = st_reg.target;
    assign move_reverse                = st_reg.reverse;
    assign move_entry                  = st_reg.entry;
    assign move_direct                 = st_reg.direct;
    assign move_speed                  = st_reg.speed;
    assign torque_post_select          = st_reg.torque_post;

endmodule // spx_drive

/* design/spx_master.sv */
`timescale 1ns/100ps
module spx_master
    import spx_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    spx_link_if.master       link,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [2:0]           ctrl;
        logic [STATION_W-1:0] station;
        logic [SPEED_W-1:0]   speed;
        logic [REG_W-1:0]     next_reg;
        logic [REG_W-1:0]     tos_reg;
        logic                 start;
        logic [2:0]           hold;
        logic [31:0]          rdata;
        logic                 err;
    } spx_master_state_type;

    spx_master_state_type st_reg;
    spx_master_state_type st_next;

    logic access;
    logic mapped;

    assign access = psel && penable;
    assign mapped = (paddr <= OFS_STATUS) && (paddr[1:0] == 2'h0);

    // Register writes, reads and start pulse shaping
    always_comb begin
        st_next     = st_reg;
        st_next.err = 1'b0;
        if (st_reg.start) begin
            if (st_reg.hold == 3'h0) begin
                st_next.start = 1'b0;
            end else begin
                st_next.hold = st_reg.hold - 1'b1;
            end
        end
        if (psel && !penable) begin
            st_next.err   = !mapped;
            st_next.rdata = 32'h0;
            if (!pwrite) begin
                unique case (paddr)
                    OFS_CTRL:     st_next.rdata = 32'(st_reg.ctrl);
                    OFS_STATION:  st_next.rdata = 32'(st_reg.station);
                    OFS_SPEED:    st_next.rdata = 32'(st_reg.speed);
                    OFS_NEXT_REG: st_next.rdata = 32'(st_reg.next_reg);
                    OFS_TOS_REG:  st_next.rdata = 32'(st_reg.tos_reg);
                    OFS_STATUS:   st_next.rdata = {27'h0, st_reg.start,
                        link.station_range_warning,
                        link.home_not_done_alarm,
                        link.movement_complete_flag,
                        link.in_position_flag};
                    default:      st_next.rdata = 32'h0;
                endcase
            end
        end
        if (access && pwrite) begin
            unique case (paddr)
                OFS_CTRL:     st_next.ctrl     = pwdata[2:0];        // R9 R10
                OFS_STATION:  st_next.station  = pwdata[STATION_W-1:0];
                OFS_SPEED:    st_next.speed    = pwdata[SPEED_W-1:0];
                OFS_NEXT_REG: st_next.next_reg = pwdata[REG_W-1:0];
                OFS_TOS_REG:  st_next.tos_reg  = pwdata[REG_W-1:0];
                OFS_CMD: begin
                    // Start only once the previous move has completed
                    if (pwdata[CMD_START_BIT] && !st_reg.start
                        && link.movement_complete_flag) begin        // R3
                        st_next.start = 1'b1;
                        st_next.hold  = 3'(START_HOLD_CYCLES - 1);
                    end
                end
                default: ;
            endcase
        end
    end

    // State register
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_reg      <= '0;
            st_reg.ctrl <= CTRL_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------------------------------
    // Bus and link outputs
    // ----------------------------------------------------------------
    assign pready  = 1'b1;
    assign prdata  = st_reg.rdata;
    assign pslverr = st_reg.err && access;

    // Selections driven continuously, ahead of any start
    assign link.start_request_bit               = st_reg.start;      // R15
    assign link.op_mode_select_first            = st_reg.ctrl[CTRL_MODE1_BIT];
    assign link.op_mode_select_second           = st_reg.ctrl[CTRL_MODE2_BIT];
    assign link.register_select_system_bit      = st_reg.ctrl[CTRL_RSEL_BIT];
    assign link.target_station_select_low_bits  = st_reg.station[4:0]; // R18
    assign link.target_station_select_high_bits = st_reg.station[7:5];
    assign link.speed_select_bits               = st_reg.speed;
    assign link.next_station_remote_register    = st_reg.next_reg;   // R7
    assign link.table_or_speed_remote_register  = st_reg.tos_reg;

endmodule // spx_master

/* tb/spx_link_sva.sv */
`timescale 1ns/100ps
module spx_link_sva
    import spx_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic start_request_bit,
    input wire logic op_mode_select_first,
    input wire logic op_mode_select_second,
    input wire logic indexer_selected,
    input wire logic in_position_flag,
    input wire logic movement_complete_flag,
    input wire logic home_not_done_alarm,
    input wire logic station_range_warning
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    // ------------------------------------------------------------
    // Link checks
    // ------------------------------------------------------------
    a_start_hold: assert property (
        $rose(start_request_bit) |-> start_request_bit[*4] ##1
        !start_request_bit) else $error("start pulse length wrong");
    a_start_wait: assert property (
        $rose(start_request_bit) |-> $past(movement_complete_flag))
        else $error("start raised while move running");
    a_complete_drop: assert property (
        $rose(start_request_bit) && movement_complete_flag &&
        op_mode_select_first && op_mode_select_second &&
        indexer_selected |-> ##[1:2]
        (!movement_complete_flag || home_not_done_alarm ||
        station_range_warning)) else $error("complete kept at start");
    a_inpos_drop: assert property (
        $fell(movement_complete_flag) |-> !in_position_flag)
        else $error("in position kept at move start");
    a_inpos_follow: assert property (
        $rose(movement_complete_flag) |-> in_position_flag)
        else $error("in position missing at arrival");
    a_alarm_cause: assert property (
        $rose(home_not_done_alarm) |-> $past(start_request_bit))
        else $error("alarm without start");
    a_alarm_no_move: assert property (
        $rose(home_not_done_alarm) |-> movement_complete_flag[*2])
        else $error("alarm started a move");
    a_warn_cause: assert property (
        $rose(station_range_warning) |-> $past(start_request_bit))
        else $error("warning without start");
    a_warn_no_move: assert property (
        $rose(station_range_warning) |-> movement_complete_flag[*2])
        else $error("warning started a move");
endmodule // spx_link_sva

/* tb/shortest_path_indexer_control_test.sv */
`timescale 1ns/100ps
module shortest_path_indexer_control_test;
    import spx_pkg::*;
    logic        clk_sys, nrst, psel, penable, pwrite, pready, pslverr;
    logic        two_st, home_done, alarm_clear, pos_in, arrived, method;
    logic        mv_start, mv_rev, mv_dir, torque, c_rev, c_dir;
    logic [7:0]  paddr, cur_st, mv_tgt, c_tgt;
    logic [31:0] pwdata, prdata, q;
    logic [3:0]  opsel, mv_ent, c_ent;
    logic [8:0]  st_count;
    logic [15:0] mv_spd, c_spd;
    logic        e;
    int          bad_count, tests_run, starts_seen, i, n;

    spx_link_if spx_link_if_i ();
    spx_master spx_master_i (.clk_sys(clk_sys), .nrst(nrst),
        .link(spx_link_if_i), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    spx_drive #(.DELAY_W(16)) spx_drive_i (.clk_sys(clk_sys), .nrst(nrst),
        .link(spx_link_if_i), .operation_select_param(opsel),
        .station_count_param(st_count), .speed_data_method_param(method),
        .torque_limit_delay_param(16'h0003), .two_stations_occupied(two_st),
        .home_return_done(home_done), .alarm_clear(alarm_clear),
        .position_in_range(pos_in), .current_station(cur_st),
        .move_arrived(arrived), .move_start(mv_start), .move_target(mv_tgt),
        .move_reverse(mv_rev), .move_entry(mv_ent), .move_direct(mv_dir),
        .move_speed(mv_spd), .torque_post_select(torque));
    spx_link_sva spx_link_sva_i (.clk_sys(clk_sys), .nrst(nrst),
        .start_request_bit(spx_link_if_i.start_request_bit),
        .op_mode_select_first(spx_link_if_i.op_mode_select_first),
        .op_mode_select_second(spx_link_if_i.op_mode_select_second),
        .indexer_selected(opsel == OPSEL_INDEXER),
        .in_position_flag(spx_link_if_i.in_position_flag),
        .movement_complete_flag(spx_link_if_i.movement_complete_flag),
        .home_not_done_alarm(spx_link_if_i.home_not_done_alarm),
        .station_range_warning(spx_link_if_i.station_range_warning));

    // Clock
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // Capture of each move order
    always @(posedge clk_sys) begin
        if (mv_start === 1'b1) begin
            starts_seen <= starts_seen + 1;
            c_tgt <= mv_tgt;
            c_ent <= mv_ent;
            c_rev <= mv_rev;
            c_dir <= mv_dir;
            c_spd <= mv_spd;
        end
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: %s", $time, what);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic clr();
        alarm_clear <= 1'b1;
        @(posedge clk_sys);
        alarm_clear <= 1'b0;
        @(posedge clk_sys);
    endtask

    // Start a move, judge the order, then finish it
    task automatic do_move(input logic [7:0] tgt, input logic [3:0] ent,
                           input logic rev, input logic dir,
                           input logic [15:0] spd);
        n = starts_seen;
        apb(1'b1, OFS_CMD, 32'h1);
        for (i = 0; i < 20 && starts_seen == n; i++) @(posedge clk_sys);
        chk(starts_seen, n + 1, "move not started");
        chk(c_tgt, tgt, "target station");
        chk(c_ent, ent, "table entry");
        chk(c_rev, rev, "rotation direction");
        chk(c_dir, dir, "speed method");
        if (dir) chk(c_spd, spd, "direct speed");
        apb(1'b1, OFS_SPEED, 32'h7);
        apb(1'b1, OFS_CMD, 32'h1);
        repeat (4) @(posedge clk_sys);
        chk(starts_seen, n + 1, "start accepted during move");
        chk(mv_ent, ent, "entry changed during move");
        arrived <= 1'b1;
        @(posedge clk_sys);
        arrived <= 1'b0;
        for (i = 0; i < 20 && spx_link_if_i.in_position_flag !== 1'b1; i++)
            @(posedge clk_sys);
        chk(spx_link_if_i.movement_complete_flag, 1, "no complete");
        repeat (3) @(posedge clk_sys);
        chk(torque, 0, "torque limit switched early");
        @(posedge clk_sys);
        chk(torque, 1, "torque limit not switched");
    endtask

    // Start that must be refused with a flag
    task automatic refused(input int use_alarm);
        n = starts_seen;
        apb(1'b1, OFS_CMD, 32'h1);
        for (i = 0; i < 20; i++) @(posedge clk_sys);
        chk(starts_seen, n, "refused start moved");
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(q & 32'hE, use_alarm ? 32'h6 : 32'hA, "flag");
        clr();
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {psel, penable, pwrite, paddr, pwdata, arrived, alarm_clear} = '0;
        {nrst, home_done, method, cur_st} = '0;
        {two_st, pos_in} = 2'b11;
        opsel = 4'h1;
        st_count = 9'h008;
        repeat (16) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(q & 32'h3, 32'h3, "power-on status");
        apb(1'b0, 8'h1C, 32'h0);
        chk({q[30:0], e}, 32'h1, "unmapped address");
        apb(1'b1, OFS_CTRL, 32'h3);
        apb(1'b1, OFS_STATION, 32'h7);
        apb(1'b1, OFS_SPEED, 32'h2);
        refused(1);
        home_done <= 1'b1;
        do_move(8'h07, 4'h3, 1'b1, 1'b0, 16'h0);
        apb(1'b1, OFS_STATION, 32'h8);
        refused(0);
        apb(1'b1, OFS_STATION, 32'h1);
        opsel <= 4'h0;
        n = starts_seen;
        apb(1'b1, OFS_CMD, 32'h1);
        repeat (10) @(posedge clk_sys);
        chk(starts_seen, n, "moved with indexer off");
        opsel <= 4'h1;
        apb(1'b1, OFS_CTRL, 32'h7);
        apb(1'b1, OFS_NEXT_REG, 32'h3);
        apb(1'b1, OFS_TOS_REG, 32'h6);
        do_move(8'h03, 4'h6, 1'b0, 1'b0, 16'h0);
        method <= 1'b1;
        apb(1'b1, OFS_NEXT_REG, 32'h4);
        apb(1'b1, OFS_TOS_REG, 32'h1234);
        do_move(8'h04, ENTRY_FIRST, 1'b0, 1'b1, 16'h1234);
        give_verdict();
    end

    // Watchdog
    initial begin
        repeat (20000) @(posedge clk_sys);
        bad_count++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        give_verdict();
    end
endmodule // shortest_path_indexer_control_test
